/* hic_panel.sv */
// front panel model driving the active-low command pins
`timescale 1ns/1ps
`default_nettype none
module hic_panel
  import hic_pkg::*;
(
  input wire logic clock_i,
  input wire logic [NUM_CMD-1:0] press_i,
  output logic [NUM_CMD-1:0] pin_n_o
);
  logic [NUM_CMD-1:0][2:0] low_cnt_reg = '0;
  // ----------------------------------------------------------------------
  // one pulse per press, four clocks low, then idle high
  // ----------------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    for (int k = 0; k < NUM_CMD; k++)
    begin
      if (press_i[k])
        low_cnt_reg[k] <= 3'h4;
      else if (low_cnt_reg[k] != 3'h0)
        low_cnt_reg[k] <= low_cnt_reg[k] - 3'h1;
    end
  end
  always_comb
  begin
    for (int k = 0; k < NUM_CMD; k++)
      pin_n_o[k] = (low_cnt_reg[k] == 3'h0);
  end
endmodule
`default_nettype wire

/* hic_pkg.sv */
// constants, types and register map of the hold and integration controller
package hic_pkg;
  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLOCK_PERIOD_NS = 50;
  localparam int SECOND_NS = 1_000_000_000;
  localparam int SECOND_CYCLES = SECOND_NS / CLOCK_PERIOD_NS;
  localparam int MAX_INTEG_HOURS = 10000;
  localparam int SECONDS_PER_HOUR = 3600;
  localparam int TIME_W = 26;
  localparam logic [TIME_W-1:0] MAX_INTEG_SECONDS = TIME_W'(MAX_INTEG_HOURS * SECONDS_PER_HOUR);
  // ----------------------------------------------------------------------
  // data shapes
  // ----------------------------------------------------------------------
  localparam int NUM_QTY = 11;
  localparam int QTY_W = 16;
  localparam int ACC_W = 32;
  localparam int ACTIVE_POWER_IDX = 2;
  localparam logic signed [ACC_W-1:0] ACC_MAX = 32'sh7FFF_FFFF;
  localparam logic signed [ACC_W-1:0] ACC_MIN = 32'sh8000_0000;
  typedef logic signed [QTY_W-1:0] hic_qty_t;
  typedef struct packed {
    hic_qty_t [NUM_QTY-1:0] qty;
  } hic_meas_t;
  // ----------------------------------------------------------------------
  // register map, byte addresses
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_CMD = 8'h04;
  localparam logic [ADDR_W-1:0] REG_TIMER = 8'h08;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_ELAPSED = 8'h10;
  localparam logic [ADDR_W-1:0] REG_ACCUM = 8'h14;
  localparam logic [ADDR_W-1:0] REG_AVERAGE = 8'h18;
  localparam logic [ADDR_W-1:0] REG_DISPLAY0 = 8'h20;
  localparam int WORD_SHIFT = 2;
  // ctrl fields
  localparam int CTRL_MAX_EN = 0;
  localparam int CTRL_CONT = 1;
  // command fields, also the index of each external pin
  localparam int NUM_CMD = 5;
  localparam int CMD_HOLD = 0;
  localparam int CMD_SINGLE = 1;
  localparam int CMD_START = 2;
  localparam int CMD_STOP = 3;
  localparam int CMD_CLEAR = 4;
  // status fields
  localparam int ST_HOLD = 0;
  localparam int ST_ACTIVE = 1;
  localparam int ST_LIMIT = 2;
  localparam int ST_SINGLE = 3;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  typedef enum logic {
    INT_STOPPED,
    INT_RUNNING
  } hic_int_state_t;
endpackage

/* hic_top.sv */
// hold, max tracking and integration control with an ahb-lite register slave
//
// Implementation choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module hic_top
  import hic_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = SECOND_CYCLES
)(
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic meas_valid_i,
  input wire hic_meas_t meas_i,
  input wire logic external_freeze_toggle_n_i,
  input wire logic external_held_update_n_i,
  input wire logic external_start_n_i,
  input wire logic external_stop_n_i,
  input wire logic external_integration_clear_n_i,
  output hic_meas_t display_o,
  output logic hold_active_o,
  output logic measure_restart_o,
  output logic integration_active_output_o
);
  // ----------------------------------------------------------------------
  // external pulse pins: sync, then falling edge
  // ----------------------------------------------------------------------
  logic [NUM_CMD-1:0] pin_n;
  logic [NUM_CMD-1:0] sync1_reg;
  logic [NUM_CMD-1:0] sync2_reg;
  logic [NUM_CMD-1:0] sync3_reg;
  logic [NUM_CMD-1:0] pin_evt;
  assign pin_n = {external_integration_clear_n_i, external_stop_n_i, external_start_n_i,
                  external_held_update_n_i, external_freeze_toggle_n_i};
  genvar g;
  generate
    for (g = 0; g < NUM_CMD; g++)
    begin : g_pin
      always_ff @(posedge clock_i or negedge reset_n_i)
      begin
        if (!reset_n_i)
        begin
          sync1_reg[g] <= 1'b1;
          sync2_reg[g] <= 1'b1;
          sync3_reg[g] <= 1'b1;
        end
        else
        begin
          sync1_reg[g] <= pin_n[g];
          sync2_reg[g] <= sync1_reg[g];
          sync3_reg[g] <= sync2_reg[g];
        end
      end
      assign pin_evt[g] = sync3_reg[g] & ~sync2_reg[g];
    end
  endgenerate

  // ----------------------------------------------------------------------
  // ahb-lite slave, zero wait states
  // ----------------------------------------------------------------------
  logic wr_pend_reg;
  logic [ADDR_W-1:0] wr_addr_reg;
  logic addr_phase;
  logic [ADDR_W-1:0] addr_now;
  logic [NUM_CMD-1:0] sw_cmd;
  logic [NUM_CMD-1:0] cmd;
  logic [1:0] ctrl_reg;
  logic [TIME_W-1:0] timer_reg;
  logic hold_reg;
  logic single_pend_reg;
  logic limit_reg;
  hic_int_state_t state_reg;
  logic [TIME_W-1:0] elapsed_reg;
  logic [31:0] sec_cnt_reg;
  logic signed [ACC_W-1:0] acc_reg;
  logic signed [ACC_W-1:0] avg_reg;
  hic_meas_t disp_reg;

  assign addr_phase = hsel_i & htrans_i[1] & hready_i;
  assign addr_now = haddr_i[ADDR_W-1:0];
  assign sw_cmd = (wr_pend_reg && wr_addr_reg == REG_CMD) ? hwdata_i[NUM_CMD-1:0] : '0;
  assign cmd = sw_cmd | pin_evt;

  function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] idx;
    idx = ADDR_W'((a - REG_DISPLAY0) >> WORD_SHIFT);
    if (a == REG_CTRL)
      read_word = {30'h0000_0000, ctrl_reg};
    else if (a == REG_TIMER)
      read_word = {6'h00, timer_reg};
    else if (a == REG_STATUS)
      read_word = {28'h000_0000, single_pend_reg, limit_reg, state_reg == INT_RUNNING, hold_reg};
    else if (a == REG_ELAPSED)
      read_word = {6'h00, elapsed_reg};
    else if (a == REG_ACCUM)
      read_word = acc_reg;
    else if (a == REG_AVERAGE)
      read_word = avg_reg;
    else if (a >= REG_DISPLAY0 && idx < ADDR_W'(NUM_QTY) && a[1:0] == 2'b00)
      read_word = {{16{disp_reg.qty[idx][QTY_W-1]}}, disp_reg.qty[idx]};
    else
      read_word = ZERO_WORD;
  endfunction

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
      hrdata_o <= ZERO_WORD;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
    else
    begin
      wr_pend_reg <= addr_phase & hwrite_i;
      if (addr_phase)
        wr_addr_reg <= addr_now;
      if (addr_phase && !hwrite_i)
        hrdata_o <= read_word(addr_now);
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ctrl_reg <= '0;
      timer_reg <= '0;
    end
    else if (wr_pend_reg)
    begin
      if (wr_addr_reg == REG_CTRL)
        ctrl_reg <= hwdata_i[1:0];
      if (wr_addr_reg == REG_TIMER)
        timer_reg <= hwdata_i[TIME_W-1:0];
    end
  end

  // ----------------------------------------------------------------------
  // hold, single capture and max tracking
  // ----------------------------------------------------------------------
  logic capture;
  assign capture = meas_valid_i & (~hold_reg | single_pend_reg);

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      hold_reg <= 1'b0;
      single_pend_reg <= 1'b0;
      measure_restart_o <= 1'b0;
    end
    else
    begin
      measure_restart_o <= cmd[CMD_SINGLE] & ~hold_reg;
      if (cmd[CMD_HOLD])
        hold_reg <= ~hold_reg;
      // a request landing on the capture tick arms the next tick
      if (cmd[CMD_SINGLE] && hold_reg)
        single_pend_reg <= 1'b1;
      else if (meas_valid_i || cmd[CMD_HOLD])
        single_pend_reg <= 1'b0;
    end
  end

  generate
    for (g = 0; g < NUM_QTY; g++)
    begin : g_qty
      always_ff @(posedge clock_i or negedge reset_n_i)
      begin
        if (!reset_n_i)
          disp_reg.qty[g] <= '0;
        else if (capture)
        begin
          if (!ctrl_reg[CTRL_MAX_EN] || meas_i.qty[g] > disp_reg.qty[g])
            disp_reg.qty[g] <= meas_i.qty[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      display_o <= '0;
      hold_active_o <= 1'b0;
    end
    else
    begin
      display_o <= disp_reg;
      hold_active_o <= hold_reg;
    end
  end

  // ----------------------------------------------------------------------
  // integrator
  // ----------------------------------------------------------------------
  logic sec_tick;
  logic manual_mode;
  logic timer_hit;
  logic signed [ACC_W:0] acc_sum;
  logic acc_sat;
  assign sec_tick = (sec_cnt_reg == SEC_CYCLES - 1);
  assign manual_mode = (timer_reg == '0);
  assign timer_hit = sec_tick && (elapsed_reg + 1'b1 == (manual_mode ? MAX_INTEG_SECONDS : timer_reg));
  assign acc_sum = acc_reg + meas_i.qty[ACTIVE_POWER_IDX];
  assign acc_sat = acc_sum > ACC_MAX || acc_sum < ACC_MIN || acc_sum == ACC_MAX || acc_sum == ACC_MIN;

  // free-running base, so a run may see its first second early
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      sec_cnt_reg <= '0;
    else if (sec_tick)
      sec_cnt_reg <= '0;
    else
      sec_cnt_reg <= sec_cnt_reg + 1'b1;
  end

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_reg <= INT_STOPPED;
      integration_active_output_o <= 1'b0;
      limit_reg <= 1'b0;
      elapsed_reg <= '0;
      acc_reg <= '0;
    end
    else if (cmd[CMD_CLEAR])
    begin
      state_reg <= INT_STOPPED;
      integration_active_output_o <= 1'b0;
      limit_reg <= 1'b0;
      elapsed_reg <= '0;
      acc_reg <= '0;
    end
    else
    begin
      case (state_reg)
        INT_STOPPED:
        begin
          if (cmd[CMD_START] && !limit_reg && !cmd[CMD_STOP])
          begin
            state_reg <= INT_RUNNING;
            integration_active_output_o <= 1'b1;
          end
        end
        INT_RUNNING:
        begin
          if (meas_valid_i)
            acc_reg <= acc_sat ? (acc_sum < 0 ? ACC_MIN : ACC_MAX) : acc_sum[ACC_W-1:0];
          if (sec_tick)
            elapsed_reg <= elapsed_reg + 1'b1;
          if (cmd[CMD_STOP])
          begin
            state_reg <= INT_STOPPED;
            integration_active_output_o <= 1'b0;
          end
          else if (meas_valid_i && acc_sat)
          begin
            state_reg <= INT_STOPPED;
            integration_active_output_o <= 1'b0;
            limit_reg <= 1'b1;
          end
          else if (timer_hit && ctrl_reg[CTRL_CONT] && !manual_mode)
          begin
            elapsed_reg <= '0;
            acc_reg <= '0;
          end
          else if (timer_hit)
          begin
            state_reg <= INT_STOPPED;
            integration_active_output_o <= 1'b0;
            limit_reg <= 1'b1;
          end
        end
        default:
        begin
          state_reg <= INT_STOPPED;
          integration_active_output_o <= 1'b0;
        end
      endcase
    end
  end

  // divider is wide but only feeds a slow software read
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      avg_reg <= '0;
    else if (elapsed_reg == '0)
      avg_reg <= '0;
    else
      avg_reg <= acc_reg / $signed({6'h00, elapsed_reg});
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  hold_freeze_a: assert property (hold_reg && !single_pend_reg |=> $stable(disp_reg))
    else $error("display changed while held");
  hold_output_a: assert property (##1 display_o == $past(disp_reg))
    else $error("display output not the held copy");
  single_once_a: assert property (hold_reg && single_pend_reg && meas_valid_i && !cmd[CMD_SINGLE] && !cmd[CMD_HOLD]
    |=> !single_pend_reg && hold_reg ##1 (!single_pend_reg || $past(cmd[CMD_SINGLE])))
    else $error("single capture not one shot");
  restart_pulse_a: assert property (cmd[CMD_SINGLE] && !hold_reg |=> measure_restart_o ##1 (!measure_restart_o
    || $past(cmd[CMD_SINGLE])))
    else $error("restart pulse missing");
  max_keep_a: assert property (ctrl_reg[CTRL_MAX_EN] && capture |=> disp_reg.qty[0] >= $past(disp_reg.qty[0]))
    else $error("max tracking lost a maximum");
  busy_out_a: assert property (integration_active_output_o == (state_reg == INT_RUNNING))
    else $error("active output disagrees with run state");
  stopped_time_a: assert property (state_reg == INT_STOPPED && !cmd[CMD_CLEAR]
    |=> $stable(elapsed_reg) && $stable(acc_reg))
    else $error("stopped integrator changed");
  sat_stop_a: assert property (state_reg == INT_RUNNING && meas_valid_i && acc_sat && !cmd[CMD_CLEAR]
    |=> state_reg == INT_STOPPED && (limit_reg || $past(cmd[CMD_STOP])))
    else $error("saturation did not stop the run");
  cont_wrap_a: assert property (state_reg == INT_RUNNING && timer_hit && ctrl_reg[CTRL_CONT] && !manual_mode
    && !cmd[CMD_STOP] && !cmd[CMD_CLEAR] && !(meas_valid_i && acc_sat)
    |=> state_reg == INT_RUNNING && elapsed_reg == '0 && acc_reg == '0)
    else $error("continuous run did not restart");
  timed_stop_a: assert property (state_reg == INT_RUNNING && timer_hit && (manual_mode || !ctrl_reg[CTRL_CONT])
    && !cmd[CMD_CLEAR] && !cmd[CMD_STOP] |=> state_reg == INT_STOPPED ##1 state_reg == INT_STOPPED)
    else $error("timer expiry did not stop the run");
  start_ignored_a: assert property (state_reg == INT_RUNNING && cmd[CMD_START] && !cmd[CMD_STOP] && !cmd[CMD_CLEAR]
    && !meas_valid_i && !sec_tick |=> $stable(acc_reg) && $stable(elapsed_reg))
    else $error("start while running changed the result");

  run_start_c: cover property (state_reg == INT_STOPPED ##1 state_reg == INT_RUNNING);
  cont_wrap_c: cover property (state_reg == INT_RUNNING && timer_hit && ctrl_reg[CTRL_CONT] && !manual_mode);
  single_c: cover property (hold_reg && single_pend_reg && meas_valid_i);
  sat_c: cover property (state_reg == INT_RUNNING && meas_valid_i && acc_sat);
endmodule
`default_nettype wire

/* hic_top_bench.sv */
// self-checking bench of the hold and integration controller
`timescale 1ns/1ps
`default_nettype none
module hic_top_bench;
  import hic_pkg::*;
  logic clock_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic hsel_i = 1'b0;
  logic [31:0] haddr_i = 32'h0000_0000;
  logic [1:0] htrans_i = 2'b00;
  logic hwrite_i = 1'b0;
  logic [2:0] hsize_i = 3'h2;
  logic [31:0] hwdata_i = 32'h0000_0000;
  logic [31:0] hrdata_o;
  logic hreadyout_o;
  logic hresp_o;
  logic meas_valid_i = 1'b0;
  hic_meas_t meas_i = '0;
  logic [NUM_CMD-1:0] press = '0;
  logic [NUM_CMD-1:0] pin_n;
  hic_meas_t display_o;
  logic hold_active_o;
  logic measure_restart_o;
  logic integration_active_output_o;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [31:0] e;
  logic [31:0] d;
  logic seen;

  // short seconds keep the timer runs brief
  hic_top #(.SEC_CYCLES(20)) hic_top_inst (.clock_i(clock_i), .reset_n_i(reset_n_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
    .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .meas_valid_i(meas_valid_i), .meas_i(meas_i), .external_freeze_toggle_n_i(pin_n[CMD_HOLD]),
    .external_held_update_n_i(pin_n[CMD_SINGLE]), .external_start_n_i(pin_n[CMD_START]),
    .external_stop_n_i(pin_n[CMD_STOP]), .external_integration_clear_n_i(pin_n[CMD_CLEAR]),
    .display_o(display_o), .hold_active_o(hold_active_o), .measure_restart_o(measure_restart_o),
    .integration_active_output_o(integration_active_output_o));
  hic_panel hic_panel_inst (.clock_i(clock_i), .press_i(press), .pin_n_o(pin_n));

  initial
  begin
    forever #25 clock_i = ~clock_i;
  end
  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic close_out();
    if (errors == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 100000)
    begin
      errors++;
      close_out();
    end
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      $display("ERROR %s expected %h seen %h", name, exp, got);
      errors++;
    end
  endtask
  // single transfer; hready sampled at each phase end, no fixed latency assumed
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clock_i);
    hsel_i <= 1'b1;
    haddr_i <= {24'h00_0000, a};
    htrans_i <= 2'b10;
    hwrite_i <= w;
    do @(posedge clock_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'b00;
    hwdata_i <= wd;
    do @(posedge clock_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] x;
    bus(1'b1, a, v, x);
  endtask
  task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, ZERO_WORD, x);
    chk(name, exp, x);
    chk("hresp_o", ZERO_WORD, hresp_o);
  endtask
  task automatic drive(input logic signed [15:0] v, input logic valid);
    for (int k = 0; k < NUM_QTY; k++)
      meas_i.qty[k] <= v;
    meas_valid_i <= valid;
  endtask
  task automatic tick(input logic signed [15:0] v);
    @(posedge clock_i);
    drive(v, 1'b1);
    @(posedge clock_i);
    meas_valid_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    #1;
  endtask
  task automatic push(input int k);
    @(posedge clock_i);
    press <= 5'h01 << k;
    @(posedge clock_i);
    press <= '0;
    repeat (10) @(posedge clock_i);
    #1;
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 300 && integration_active_output_o !== 1'b0; i++)
      @(posedge clock_i);
    #1;
  endtask
  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_hold_single();
    tick(16'sh0005);
    wr(REG_CMD, 32'h0000_0001);
    tick(16'sh0009);
    chk("display_o", 32'h0000_0005, display_o.qty[0]);
    chk("hold_active_o", 32'h0000_0001, hold_active_o);
    rdc("display0", REG_DISPLAY0, 32'h0000_0005);
    wr(REG_CMD, 32'h0000_0002);
    tick(16'sh0007);
    chk("display_o", 32'h0000_0007, display_o.qty[0]);
    tick(16'sh0008);
    chk("display_o", 32'h0000_0007, display_o.qty[ACTIVE_POWER_IDX]);
    wr(REG_CMD, 32'h0000_0001);
    seen = 1'b0;
    wr(REG_CMD, 32'h0000_0002);
    for (int i = 0; i < 4; i++)
    begin
      seen |= (measure_restart_o === 1'b1);
      @(posedge clock_i);
      #1;
    end
    chk("measure_restart_o", 32'h0000_0001, seen);
    tick(16'sh0006);
    chk("display_o", 32'h0000_0006, display_o.qty[0]);
  endtask
  task automatic t_max();
    wr(REG_CTRL, 32'h0000_0001);
    tick(16'sh000A);
    tick(16'sh0003);
    tick(-16'sh0002);
    chk("display_o", 32'h0000_000A, display_o.qty[0]);
    rdc("display0", REG_DISPLAY0, 32'h0000_000A);
    wr(REG_CTRL, 32'h0000_0000);
    tick(16'sh0003);
    chk("display_o", 32'h0000_0003, display_o.qty[0]);
  endtask
  task automatic t_manual();
    wr(REG_TIMER, 32'h0000_0000);
    wr(REG_CMD, 32'h0000_0004);
    chk("active", 32'h0000_0001, integration_active_output_o);
    tick(16'sh0064);
    tick(16'sh0064);
    repeat (70) @(posedge clock_i);
    chk("active", 32'h0000_0001, integration_active_output_o);
    wr(REG_CMD, 32'h0000_0008);
    chk("active", 32'h0000_0000, integration_active_output_o);
    rdc("accum", REG_ACCUM, 32'h0000_00C8);
    bus(1'b0, REG_ELAPSED, ZERO_WORD, e);
    chk("elapsed_in_range", 32'h0000_0001, e >= 4 && e <= 5);
    repeat (50) @(posedge clock_i);
    rdc("elapsed", REG_ELAPSED, e);
    wr(REG_CMD, 32'h0000_0008);
    rdc("accum", REG_ACCUM, 32'h0000_00C8);
    rdc("average", REG_AVERAGE, 32'd200 / e);
    wr(REG_CMD, 32'h0000_0010);
    rdc("accum", REG_ACCUM, ZERO_WORD);
  endtask
  task automatic t_timed();
    wr(REG_TIMER, 32'h0000_0002);
    wr(REG_CMD, 32'h0000_0004);
    tick(16'sh0007);
    wait_idle();
    chk("active", 32'h0000_0000, integration_active_output_o);
    rdc("accum", REG_ACCUM, 32'h0000_0007);
    rdc("elapsed", REG_ELAPSED, 32'h0000_0002);
    rdc("status", REG_STATUS, 32'h0000_0004);
  endtask
  task automatic t_cont();
    wr(REG_CMD, 32'h0000_0010);
    wr(REG_CTRL, 32'h0000_0002);
    wr(REG_TIMER, 32'h0000_0003);
    wr(REG_CMD, 32'h0000_0004);
    tick(16'sh001E);
    d = 32'h0000_001E;
    for (int i = 0; i < 60 && d !== ZERO_WORD; i++)
      bus(1'b0, REG_ACCUM, ZERO_WORD, d);
    chk("accum_cleared", ZERO_WORD, d);
    chk("active", 32'h0000_0001, integration_active_output_o);
    tick(16'sh0006);
    wr(REG_CMD, 32'h0000_0004);
    wr(REG_CMD, 32'h0000_0008);
    chk("active", 32'h0000_0000, integration_active_output_o);
    rdc("accum", REG_ACCUM, 32'h0000_0006);
    wr(REG_CTRL, 32'h0000_0000);
  endtask
  task automatic t_pins();
    push(CMD_START);
    chk("active", 32'h0000_0001, integration_active_output_o);
    push(CMD_STOP);
    chk("active", 32'h0000_0000, integration_active_output_o);
    push(CMD_CLEAR);
    rdc("accum", REG_ACCUM, ZERO_WORD);
    tick(16'sh0002);
    push(CMD_HOLD);
    tick(16'sh0009);
    chk("display_o", 32'h0000_0002, display_o.qty[0]);
    push(CMD_SINGLE);
    tick(16'sh000B);
    chk("display_o", 32'h0000_000B, display_o.qty[0]);
    push(CMD_HOLD);
    chk("hold_active_o", ZERO_WORD, hold_active_o);
  endtask
  task automatic t_sat();
    wr(REG_TIMER, 32'h0000_0000);
    wr(REG_CMD, 32'h0000_0010);
    wr(REG_CMD, 32'h0000_0004);
    @(posedge clock_i);
    // a tick every cycle reaches the lowest sum in 65536 ticks
    drive(-16'sh8000, 1'b1);
    repeat (65536) @(posedge clock_i);
    meas_valid_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    #1;
    chk("active", 32'h0000_0000, integration_active_output_o);
    rdc("accum", REG_ACCUM, 32'h8000_0000);
    rdc("status", REG_STATUS, 32'h0000_0004);
  endtask

  initial
  begin
    repeat (5) @(posedge clock_i);
    reset_n_i <= 1'b1;
    t_hold_single();
    t_max();
    t_manual();
    t_timed();
    t_cont();
    t_pins();
    t_sat();
    close_out();
  end
endmodule
`default_nettype wire
